// ==== rtl/deframer_pkg.sv ====
`default_nettype none
package deframer_pkg;
	// register port geometry
	localparam int ADDR_W    = 12;
	localparam int DATA_W    = 8;
	// lanes per link and packed configuration bytes
	localparam int NUM_LANES = 5;
	localparam int CFG_BYTES = 11;
	localparam int CFG_BITS  = CFG_BYTES * 8;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_LINK_PAGE = 12'h300;
	localparam logic [ADDR_W-1:0] OFS_LANE_SYNC = 12'h473;
	localparam logic [ADDR_W-1:0] OFS_CTRL_A    = 12'h475;
	localparam logic [ADDR_W-1:0] OFS_CTRL_B    = 12'h476;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 12'h4F0;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 12'h4F1;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 12'h4F2;

	// field positions of the first control register
	localparam int BIT_SOFT_RST   = 3;
	localparam int BIT_FORCE_SYNC = 2;
	localparam int BIT_REPLACE    = 0;
	// field positions of the second control register
	localparam int BIT_QUALIFY    = 4;
	localparam int BIT_CKSUM_SEL  = 0;
	// interrupt layout: lost-sync bits from 0, achieved bits from 4
	localparam int IRQ_LOST_BASE  = 0;
	localparam int IRQ_GOOD_BASE  = 4;

	// reset values
	localparam logic RST_SOFT_RST   = 1'b0;
	localparam logic RST_FORCE_SYNC = 1'b0;
	localparam logic RST_REPLACE    = 1'b1;
	localparam logic RST_QUALIFY    = 1'b1;
	localparam logic RST_CKSUM_SEL  = 1'b0;
	localparam logic [DATA_W-1:0] RST_IRQ_EN = 8'h00;
endpackage
`default_nettype wire

// ==== rtl/cksum_calc.sv ====
`default_nettype none
module cksum_calc (
	// clock and clears
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              clr_i,
	// packed configuration and method
	input  wire logic [deframer_pkg::CFG_BITS-1:0] cfg_i,
	input  wire logic                              method_i,
	// result
	output logic [7:0]                             sum_o
);
	import deframer_pkg::*;

	logic [7:0] byte_sum;
	logic [7:0] field_sum;
	logic [7:0] b [CFG_BYTES];

	// plain byte sum of the packed table, wraps modulo 256
	always_comb begin
		byte_sum = 8'h00;
		for (int i = 0; i < CFG_BYTES; i++) begin
			b[i] = cfg_i[i*8 +: 8];
			byte_sum = byte_sum + b[i];
		end
	end

	// each field summed on its own, so packed neighbours do not carry
	assign field_sum = b[0] + {4'h0, b[1][3:0]} + {4'h0, b[1][7:4]}
		+ {3'h0, b[2][4:0]} + {7'h00, b[2][5]} + {7'h00, b[2][6]}
		+ {3'h0, b[3][4:0]} + {7'h00, b[3][7]} + b[4]
		+ {3'h0, b[5][4:0]} + b[6] + {3'h0, b[7][4:0]} + {6'h00, b[7][7:6]}
		+ {3'h0, b[8][4:0]} + {5'h00, b[8][7:5]} + {3'h0, b[9][4:0]}
		+ {5'h00, b[9][7:5]} + {3'h0, b[10][4:0]} + {7'h00, b[10][7]};

	// method picks field sum or register sum
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			sum_o <= 8'h00;
		end else begin
			sum_o <= method_i ? byte_sum : field_sum;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/err_qualify.sv ====
`default_nettype none
module err_qualify #(
	parameter int LANES = deframer_pkg::NUM_LANES
) (
	// clock and clears
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             clr_i,
	// settings
	input  wire logic             replace_en_i,
	input  wire logic             qualify_i,
	// raw errors
	input  wire logic [LANES-1:0] nit_i,
	input  wire logic [LANES-1:0] disp_i,
	input  wire logic             frame_err_i,
	// qualified results
	output logic      [LANES-1:0] disp_o,
	output logic                  replace_o
);
	logic [LANES-1:0] next_disp;

	// table miss hides disparity only when qualifying
	assign next_disp = disp_i & ~(nit_i & {LANES{qualify_i}});

	// soft reset holds the datapath at its power-on state
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			disp_o    <= '0;
			replace_o <= 1'b0;
		end else begin
			disp_o    <= next_disp;
			replace_o <= frame_err_i & replace_en_i;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/deframer_ctrl.sv ====
// Function
// - each of lanes 0 to 4 has a read-only sync flag, 1 when achieved, 0 after reset.
// - every lane sync flag and control field at 0x473 to 0x476 is banked per link, chosen by the page at 0x300; interrupt registers are shared.
// - bit 3 at 0x475 is a synchronous soft reset holding the deframer at power-on state.
// - bit 2 at 0x475 forces a synchronization request toward the transmitter.
// - bit 0 at 0x475, reset 1, makes frames received in error be replaced.
// - bit 4 at 0x476, reset 1, lets a table miss mask a concurrent disparity error.
// - bit 0 at 0x476, reset 0, selects the checksum method over reserved bits 3 to 1.
// - method 0 sums the config fields, method 1 sums bytes 0x450 to 0x45A modulo 256.
`default_nettype none
module deframer_ctrl #(
	parameter int NUM_LINKS = 2,
	parameter int LANES     = deframer_pkg::NUM_LANES
) (
	// clock and reset
	input  wire logic                                  MCLK_I,
	input  wire logic                                  SYS_RST_I,
	// register port
	input  wire logic [deframer_pkg::ADDR_W-1:0]       ADDR_I,
	input  wire logic [deframer_pkg::DATA_W-1:0]       WDATA_I,
	input  wire logic                                  WR_I,
	input  wire logic                                  RD_I,
	output logic      [deframer_pkg::DATA_W-1:0]       RDATA_O,
	// lane status and errors
	input  wire logic [NUM_LINKS*LANES-1:0]            LANE_SYNC_I,
	input  wire logic [NUM_LINKS*LANES-1:0]            NIT_ERR_I,
	input  wire logic [NUM_LINKS*LANES-1:0]            DISP_ERR_I,
	input  wire logic [NUM_LINKS-1:0]                  FRAME_ERR_I,
	input  wire logic [NUM_LINKS*deframer_pkg::CFG_BITS-1:0] CFG_I,
	// per-link outputs
	output logic      [NUM_LINKS-1:0]                  SOFT_RST_O,
	output logic      [NUM_LINKS-1:0]                  SYNC_REQ_O,
	output logic      [NUM_LINKS-1:0]                  REPLACE_O,
	output logic      [NUM_LINKS*LANES-1:0]            DISP_ERR_O,
	output logic      [NUM_LINKS*8-1:0]                CKSUM_O,
	// interrupt
	output logic                                       IRQ_O
);
	import deframer_pkg::*;

	localparam int PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;

	////////////////////////////////////////////////////////////////////////
	// state

	logic [PAGE_W-1:0]          link_page;
	logic [NUM_LINKS-1:0]       soft_rst;
	logic [NUM_LINKS-1:0]       force_sync;
	logic [NUM_LINKS-1:0]       replace_en;
	logic [NUM_LINKS-1:0]       qualify;
	logic [NUM_LINKS-1:0]       cksum_sel;
	logic [NUM_LINKS*LANES-1:0] lane_sync;
	logic [DATA_W-1:0]          irq_stat;
	logic [DATA_W-1:0]          irq_en;
	logic [DATA_W-1:0]          next_irq_stat;

	////////////////////////////////////////////////////////////////////////
	// address decode

	wire logic sel_page = (ADDR_I == OFS_LINK_PAGE);
	wire logic sel_sync = (ADDR_I == OFS_LANE_SYNC);
	wire logic sel_ctla = (ADDR_I == OFS_CTRL_A);
	wire logic sel_ctlb = (ADDR_I == OFS_CTRL_B);
	wire logic sel_stat = (ADDR_I == OFS_IRQ_STAT);
	wire logic sel_clr  = (ADDR_I == OFS_IRQ_CLR);
	wire logic sel_en   = (ADDR_I == OFS_IRQ_EN);

	// write strobes per register
	wire logic wr_page = WR_I & sel_page;
	wire logic wr_ctla = WR_I & sel_ctla;
	wire logic wr_ctlb = WR_I & sel_ctlb;
	wire logic wr_clr  = WR_I & sel_clr;
	wire logic wr_en   = WR_I & sel_en;

	// out-of-range pages are dropped so the bank index stays legal
	wire logic page_ok = (WDATA_I < DATA_W'(NUM_LINKS));

	////////////////////////////////////////////////////////////////////////
	// link page

	// the page steers every banked access below
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			link_page <= '0;
		end else if (wr_page && page_ok) begin
			link_page <= WDATA_I[PAGE_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// banked control fields

	// only the bank under the page takes a write; reserved bits are
	// never stored, so they cannot steer anything
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			soft_rst   <= {NUM_LINKS{RST_SOFT_RST}};
			force_sync <= {NUM_LINKS{RST_FORCE_SYNC}};
			replace_en <= {NUM_LINKS{RST_REPLACE}};
			qualify    <= {NUM_LINKS{RST_QUALIFY}};
			cksum_sel  <= {NUM_LINKS{RST_CKSUM_SEL}};
		end else begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				if (wr_ctla && (int'(link_page) == l)) begin
					soft_rst[l]   <= WDATA_I[BIT_SOFT_RST];
					force_sync[l] <= WDATA_I[BIT_FORCE_SYNC];
					replace_en[l] <= WDATA_I[BIT_REPLACE];
				end
				if (wr_ctlb && (int'(link_page) == l)) begin
					qualify[l]   <= WDATA_I[BIT_QUALIFY];
					cksum_sel[l] <= WDATA_I[BIT_CKSUM_SEL];
				end
			end
		end
	end

	// soft reset and sync request leave straight from their flops
	assign SOFT_RST_O = soft_rst;
	assign SYNC_REQ_O = force_sync;

	////////////////////////////////////////////////////////////////////////
	// lane sync flags

	// flags track the lanes; either reset pins them low
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			lane_sync <= '0;
		end else begin
			for (int l = 0; l < NUM_LINKS; l++) begin
				if (soft_rst[l]) begin
					lane_sync[l*LANES +: LANES] <= '0;
				end else begin
					lane_sync[l*LANES +: LANES] <= LANE_SYNC_I[l*LANES +: LANES];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-link datapath helpers

	genvar g;
	generate
		for (g = 0; g < NUM_LINKS; g++) begin : g_link
			// masking and replacement follow the banked settings
			err_qualify #(
				.LANES (LANES)
			) u_qual (
				.clk_i        (MCLK_I),
				.rst_i        (SYS_RST_I),
				.clr_i        (soft_rst[g]),
				.replace_en_i (replace_en[g]),
				.qualify_i    (qualify[g]),
				.nit_i        (NIT_ERR_I[g*LANES +: LANES]),
				.disp_i       (DISP_ERR_I[g*LANES +: LANES]),
				.frame_err_i  (FRAME_ERR_I[g]),
				.disp_o       (DISP_ERR_O[g*LANES +: LANES]),
				.replace_o    (REPLACE_O[g])
			);

			// checksum over this link's packed table
			cksum_calc u_cksum (
				.clk_i    (MCLK_I),
				.rst_i    (SYS_RST_I),
				.clr_i    (soft_rst[g]),
				.cfg_i    (CFG_I[g*CFG_BITS +: CFG_BITS]),
				.method_i (cksum_sel[g]),
				.sum_o    (CKSUM_O[g*8 +: 8])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// interrupt events

	// lost: a flag falls outside soft reset; good: all lanes come up
	wire logic [DATA_W-1:0] irq_evt;
	generate
		for (g = 0; g < 4; g++) begin : g_evt
			if (g < NUM_LINKS) begin : g_on
				wire logic [LANES-1:0] cur = lane_sync[g*LANES +: LANES];
				wire logic [LANES-1:0] nxt = LANE_SYNC_I[g*LANES +: LANES];
				assign irq_evt[IRQ_LOST_BASE+g] = |(cur & ~nxt) & ~soft_rst[g];
				assign irq_evt[IRQ_GOOD_BASE+g] = (&nxt) & ~(&cur) & ~soft_rst[g];
			end else begin : g_off
				assign irq_evt[IRQ_LOST_BASE+g] = 1'b0;
				assign irq_evt[IRQ_GOOD_BASE+g] = 1'b0;
			end
		end
	endgenerate

	// set beats clear so an event in the clear cycle survives
	assign next_irq_stat = (irq_stat & ~(wr_clr ? WDATA_I : 8'h00)) | irq_evt;

	// status, enable and the level output
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			irq_stat <= 8'h00;
			irq_en   <= RST_IRQ_EN;
			IRQ_O    <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			irq_en   <= wr_en ? WDATA_I : irq_en;
			IRQ_O    <= |(irq_stat & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	// banked views of the page in force; reserved bits forced to zero
	wire logic [DATA_W-1:0] rd_sync =
		DATA_W'(lane_sync[int'(link_page)*LANES +: LANES]);
	wire logic [DATA_W-1:0] rd_ctla = {4'h0, soft_rst[link_page],
		force_sync[link_page], 1'b0, replace_en[link_page]};
	wire logic [DATA_W-1:0] rd_ctlb = {3'h0, qualify[link_page],
		3'h0, cksum_sel[link_page]};
	wire logic [DATA_W-1:0] rd_page = DATA_W'(link_page);

	// unmapped and write-only addresses read zero
	wire logic [DATA_W-1:0] rd_mux =
		sel_page ? rd_page :
		sel_sync ? rd_sync :
		sel_ctla ? rd_ctla :
		sel_ctlb ? rd_ctlb :
		sel_stat ? irq_stat :
		sel_en   ? irq_en  : 8'h00;

	// data valid only in the cycle after the strobe
	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			RDATA_O <= 8'h00;
		end else begin
			RDATA_O <= RD_I ? rd_mux : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);

	AST_SYNC_FOLLOW: assert property (
		!soft_rst[0] |=> lane_sync[LANES-1:0] == $past(LANE_SYNC_I[LANES-1:0]))
		else $error("lane flags did not follow the lanes");

	// flags clear one edge after the soft reset lands, hence the past term
	AST_SYNC_READ: assert property (
		RD_I && sel_sync && link_page == '0 && soft_rst[0] && $past(soft_rst[0])
		|=> RDATA_O == 8'h00)
		else $error("sync flags not clear under soft reset");

	AST_PAGE_WRITE: assert property (
		wr_ctla && link_page == '0
		|=> force_sync[0] == $past(WDATA_I[BIT_FORCE_SYNC]))
		else $error("paged write missed its bank");

	AST_PAGE_OTHER: assert property (
		int'(link_page) != NUM_LINKS-1 |=> $stable(qualify[NUM_LINKS-1]))
		else $error("unpaged bank changed");

	AST_SOFT_RESET: assert property (
		soft_rst[0] |=> REPLACE_O[0] == 1'b0 && DISP_ERR_O[LANES-1:0] == '0
		&& CKSUM_O[7:0] == 8'h00)
		else $error("datapath not held under soft reset");

	AST_FORCE_SYNC: assert property (
		wr_ctla && link_page == '0 && WDATA_I[BIT_FORCE_SYNC] |=> SYNC_REQ_O[0])
		else $error("forced request not raised");

	AST_REPLACE: assert property (
		!soft_rst[0] && FRAME_ERR_I[0] |=> REPLACE_O[0] == $past(replace_en[0]))
		else $error("frame replacement wrong");

	AST_QUALIFY: assert property (
		!soft_rst[0] && DISP_ERR_I[0]
		|=> DISP_ERR_O[0] == !($past(qualify[0]) && $past(NIT_ERR_I[0])))
		else $error("disparity qualification wrong");

	AST_METHOD: assert property (
		wr_ctlb && link_page == '0 |=> cksum_sel[0] == $past(WDATA_I[BIT_CKSUM_SEL]))
		else $error("checksum method not stored");

	AST_RESERVED: assert property (
		RD_I && sel_ctla |=> RDATA_O[7:4] == 4'h0 && RDATA_O[1] == 1'b0)
		else $error("reserved bits of control a read non-zero");

	AST_RESERVED_B: assert property (
		RD_I && sel_ctlb |=> RDATA_O[7:5] == 3'h0 && RDATA_O[3:1] == 3'h0)
		else $error("reserved bits of control b read non-zero");

	AST_SYNC_FOLLOW_LAST: assert property (
		!soft_rst[NUM_LINKS-1] |=> lane_sync[NUM_LINKS*LANES-1 -: LANES]
		== $past(LANE_SYNC_I[NUM_LINKS*LANES-1 -: LANES]))
		else $error("last link flags did not follow the lanes");

	// the last bank gets the same clear as bank zero
	AST_SOFT_RESET_LAST: assert property (
		soft_rst[NUM_LINKS-1] |=> lane_sync[NUM_LINKS*LANES-1 -: LANES] == '0
		&& REPLACE_O[NUM_LINKS-1] == 1'b0 && DISP_ERR_O[NUM_LINKS*LANES-1 -: LANES] == '0
		&& CKSUM_O[NUM_LINKS*8-1 -: 8] == 8'h00)
		else $error("last link not held under soft reset");

	AST_SYNC_REQ_HOLD: assert property (
		!wr_ctla |=> $stable(SYNC_REQ_O))
		else $error("sync request moved without a control write");

	AST_QUALIFY_LAST: assert property (
		!soft_rst[NUM_LINKS-1] && DISP_ERR_I[(NUM_LINKS-1)*LANES]
		|=> DISP_ERR_O[(NUM_LINKS-1)*LANES] == !($past(qualify[NUM_LINKS-1])
		&& $past(NIT_ERR_I[(NUM_LINKS-1)*LANES])))
		else $error("last link disparity qualification wrong");

	AST_PAGE_TAKE: assert property (
		wr_page && WDATA_I < DATA_W'(NUM_LINKS)
		|=> link_page == $past(WDATA_I[PAGE_W-1:0]))
		else $error("legal page not taken");

	AST_PAGE_DROP: assert property (
		wr_page && WDATA_I >= DATA_W'(NUM_LINKS) |=> $stable(link_page))
		else $error("illegal page taken");

	// interrupt bookkeeping: set wins, clear takes written ones, level follows
	AST_IRQ_SET: assert property (
		irq_evt != 8'h00 |=> (irq_stat & $past(irq_evt)) == $past(irq_evt))
		else $error("interrupt event lost");

	AST_IRQ_CLEAR: assert property (
		wr_clr && irq_evt == 8'h00 |=> (irq_stat & $past(WDATA_I)) == 8'h00)
		else $error("interrupt status not cleared");

	AST_IRQ_LEVEL: assert property (
		1'b1 |=> IRQ_O == |($past(irq_stat) & $past(irq_en)))
		else $error("interrupt level wrong");

	AST_RDATA_IDLE: assert property (
		!RD_I |=> RDATA_O == 8'h00)
		else $error("read data outside its cycle");

	COV_SOFT_RELEASE: cover property ($fell(soft_rst[0]));
	COV_FORCE: cover property ($rose(SYNC_REQ_O[0]));
	COV_MASKED: cover property (qualify[0] && NIT_ERR_I[0] && DISP_ERR_I[0]);
	COV_IRQ: cover property ($rose(IRQ_O));
endmodule
`default_nettype wire

// ==== dv/lane_tx_model.sv ====
`default_nettype none
module lane_tx_model #(
	parameter int LINKS = 2
) (
	// clock and reset
	input  wire logic                                     clk_i,
	input  wire logic                                     rst_i,
	// bring-up and requests from the receiver
	input  wire logic                                     enable_i,
	input  wire logic [LINKS-1:0]                         sync_req_i,
	// lane status and packed configuration
	output logic      [LINKS*deframer_pkg::NUM_LANES-1:0] lane_sync_o,
	output logic      [LINKS*deframer_pkg::CFG_BITS-1:0]  cfg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import deframer_pkg::*;

	int cnt [LINKS];

	////////////////////////////////////////////////////////////////////////
	// link 0 aligns promptly, link 1 slowly, so banks never move together
	always_ff @(posedge clk_i) begin
		for (int l = 0; l < LINKS; l++) begin
			if (rst_i || !enable_i || sync_req_i[l]) begin
				cnt[l] <= 0;
				lane_sync_o[l*NUM_LANES +: NUM_LANES] <= '0;
			end else if (cnt[l] < 3 + 8 * l) begin
				cnt[l] <= cnt[l] + 1;
			end else begin
				lane_sync_o[l*NUM_LANES +: NUM_LANES] <= '1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// distinct bytes per link so a bank mix-up changes the sum
	always_comb begin
		for (int i = 0; i < LINKS * CFG_BYTES; i++) begin
			cfg_o[i*8 +: 8] = 8'h1F + 8'(i * 13);
		end
	end
endmodule
`default_nettype wire

// ==== dv/serial_link_deframer_control_test.sv ====
`default_nettype none
module serial_link_deframer_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import deframer_pkg::*;

	localparam int NL = 2;
	logic                    mclk, rst, wr, rd, link_en, irq;
	logic [ADDR_W-1:0]       addr;
	logic [7:0]              wdata, rdata;
	logic [NL*NUM_LANES-1:0] lane_sync, not_in_table_error, disp, disp_q;
	logic [NL-1:0]           frame_err, soft_rst, sync_req, repl;
	logic [NL*CFG_BITS-1:0]  cfg;
	logic [NL*8-1:0]         cksum;
	int                      failures, n_compared;

	deframer_ctrl #(.NUM_LINKS(NL)) dut_u (
		.MCLK_I(mclk), .SYS_RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .LANE_SYNC_I(lane_sync),
		.NIT_ERR_I(not_in_table_error), .DISP_ERR_I(disp), .FRAME_ERR_I(frame_err), .CFG_I(cfg),
		.SOFT_RST_O(soft_rst), .SYNC_REQ_O(sync_req), .REPLACE_O(repl),
		.DISP_ERR_O(disp_q), .CKSUM_O(cksum), .IRQ_O(irq)
	);

	lane_tx_model #(.LINKS(NL)) tx_u (
		.clk_i(mclk), .rst_i(rst), .enable_i(link_en), .sync_req_i(sync_req),
		.lane_sync_o(lane_sync), .cfg_o(cfg)
	);

	////////////////////////////////////////////////////////////////////////
	// clock and watchdog, whole run is well under 1000 cycles
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	// access and compare helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	function automatic logic [7:0] byte_sum(input int l);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < CFG_BYTES; i++) s += cfg[l*CFG_BITS + i*8 +: 8];
		return s;
	endfunction

	// every link field summed on its own, standard packing of the table
	function automatic logic [7:0] field_sum(input int l);
		logic [7:0] c [CFG_BYTES];
		for (int i = 0; i < CFG_BYTES; i++) c[i] = cfg[l*CFG_BITS + i*8 +: 8];
		return c[0] + c[1][3:0] + c[1][7:4] + c[2][4:0] + c[2][5] + c[2][6] + c[3][4:0]
			+ c[3][7] + c[4] + c[5][4:0] + c[6] + c[7][4:0] + c[7][7:6] + c[8][4:0]
			+ c[8][7:5] + c[9][4:0] + c[9][7:5] + c[10][4:0] + c[10][7];
	endfunction

	task automatic end_of_test();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		link_en = 1'b0;
		not_in_table_error = '0;
		disp = '0;
		frame_err = '0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd_chk(OFS_LANE_SYNC, 8'h00);
		rd_chk(OFS_CTRL_A, 8'h01);
		rd_chk(OFS_CTRL_B, 8'h10);
		rd_chk(12'h123, 8'h00);
		// settings only under soft reset, reserved bits set on purpose
		wr_reg(OFS_CTRL_A, 8'hFB);
		wr_reg(OFS_CTRL_B, 8'hFF);
		rd_chk(OFS_CTRL_A, 8'h09);
		rd_chk(OFS_CTRL_B, 8'h11);
		check(soft_rst, 2'b01);
		check(cksum[7:0], 8'h00);
		wr_reg(OFS_CTRL_A, 8'h01);
		step(3);
		check(cksum[7:0], byte_sum(0));
		// second bank keeps its own reset values; bad page is dropped
		wr_reg(OFS_LINK_PAGE, 8'h01);
		wr_reg(OFS_LINK_PAGE, 8'h02);
		rd_chk(OFS_LINK_PAGE, 8'h01);
		rd_chk(OFS_CTRL_A, 8'h01);
		rd_chk(OFS_CTRL_B, 8'h10);
		wr_reg(OFS_CTRL_A, 8'h08);
		wr_reg(OFS_CTRL_B, 8'h00);
		wr_reg(OFS_CTRL_A, 8'h00);
		// table miss on lane 0 beside disparity errors on every lane
		not_in_table_error <= 10'b00001_00001;
		disp <= '1;
		frame_err <= 2'b11;
		step(2);
		check(disp_q, 10'b11111_11110);
		check(repl, 2'b01);
		check(cksum[15:8], field_sum(1));
		wr_reg(OFS_CTRL_A, 8'h08);
		step(2);
		check(disp_q, 10'b00000_11110);
		wr_reg(OFS_CTRL_A, 8'h00);
		not_in_table_error <= '0;
		disp <= '0;
		frame_err <= '0;
		// both links align, then link 1 is forced to resync
		wr_reg(OFS_IRQ_EN, 8'h30);
		link_en <= 1'b1;
		for (int i = 0; i < 100 && lane_sync !== '1; i++) @(posedge mclk);
		step(3);
		rd_chk(OFS_LANE_SYNC, 8'h1F);
		rd_chk(OFS_IRQ_STAT, 8'h30);
		check(irq, 1'b1);
		wr_reg(OFS_IRQ_CLR, 8'h30);
		step(2);
		check(irq, 1'b0);
		rd_chk(OFS_IRQ_STAT, 8'h00);
		wr_reg(OFS_CTRL_A, 8'h04);
		step(1);
		check(sync_req, 2'b10);
		step(4);
		rd_chk(OFS_IRQ_STAT, 8'h02);
		check(irq, 1'b0);
		wr_reg(OFS_IRQ_EN, 8'h02);
		step(2);
		check(irq, 1'b1);
		rd_chk(OFS_LANE_SYNC, 8'h00);
		wr_reg(OFS_LINK_PAGE, 8'h00);
		rd_chk(OFS_LANE_SYNC, 8'h1F);
		wr_reg(OFS_IRQ_CLR, 8'hFF);
		step(2);
		check(irq, 1'b0);
		// link 0 is up: soft reset must still read its flags as clear
		wr_reg(OFS_CTRL_A, 8'h09);
		rd_chk(OFS_LANE_SYNC, 8'h00);
		check(soft_rst, 2'b01);
		end_of_test();
	end
endmodule
`default_nettype wire
